// *** pfs_pkg.sv ***
/*
 * pfs_pkg: shared constants of the pin function selector.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package pfs_pkg;
    // widths
    localparam int ADDR_W = 6;
    localparam int PA_W   = 8;
    localparam int PB_W   = 4;
    localparam int AN_W   = 7;
    localparam int SEL_W  = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PA_LO_SEL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_PA_HI_SEL = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_PB_LO_SEL = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_PA_DATA   = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_PA_DIR    = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_PB_DATA   = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_PB_DIR    = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_WAKE_EN   = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_BIT_OP    = 6'h20;

    // reset values
    localparam logic [7:0] RST_SEL  = 8'h00;
    localparam logic [7:0] RST_PORT = 8'hff;
    localparam logic [7:0] RST_WAKE = 8'h00;

    // select field positions
    localparam int A7_LSB = 6;
    localparam int A6_LSB = 4;
    localparam int A5_LSB = 2;
    localparam int A4_LSB = 0;
    localparam int B2_LSB = 4;
    localparam int B0_LSB = 0;

    // select codes
    localparam logic [SEL_W-1:0] SEL_C2 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_C3 = 2'h3;

    // bit operation register fields
    localparam int BOP_IDX_LSB = 0;
    localparam int BOP_VAL     = 3;
    localparam int BOP_DIR     = 4;
    localparam int BOP_PB      = 5;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pfs_pkg

// *** pfs_sel_if.sv ***
/*
 * pfs_sel_if: decoded pin routing between decoder and top.
 * Assumes one driver, the decoder, on the dec modport.
 */
`timescale 1ns/100ps
interface pfs_sel_if;
    import pfs_pkg::*;
    logic [PA_W-1:0] a_timer_drv;
    logic [PA_W-1:0] a_analog;
    logic [PB_W-1:0] b_analog;
    logic [AN_W-1:0] analog_en;
    logic            vref_en;
    logic            std_cap_en;
    logic            per_cap_en;
    logic            per_clk_en;
    logic            std_clk_en;
    logic            ext_int_en;
    modport dec (output a_timer_drv, a_analog, b_analog, analog_en,
                 vref_en, std_cap_en, per_cap_en, per_clk_en,
                 std_clk_en, ext_int_en);
    modport top (input a_timer_drv, a_analog, b_analog, analog_en,
                 vref_en, std_cap_en, per_cap_en, per_clk_en,
                 std_clk_en, ext_int_en);
endinterface : pfs_sel_if

// *** pfs_decode.sv ***
/*
 * pfs_decode: turns the select fields into per-pin routing.
 * Assumes register values come from the same clock domain.
 */
`timescale 1ns/100ps
module pfs_decode
    import pfs_pkg::*;
(
    input  wire logic [SEL_W-1:0] pa_lo_sel,
    input  wire logic [7:0]       pa_hi_sel,
    input  wire logic [7:0]       pb_lo_sel,
    pfs_sel_if.dec                sel
);
    // field extraction
    wire logic [SEL_W-1:0] a0 = pa_lo_sel;
    wire logic [SEL_W-1:0] a7 = pa_hi_sel[A7_LSB +: SEL_W];
    wire logic [SEL_W-1:0] a6 = pa_hi_sel[A6_LSB +: SEL_W];
    wire logic [SEL_W-1:0] a5 = pa_hi_sel[A5_LSB +: SEL_W];
    wire logic [SEL_W-1:0] a4 = pa_hi_sel[A4_LSB +: SEL_W];
    wire logic [SEL_W-1:0] b2 = pb_lo_sel[B2_LSB +: SEL_W];
    wire logic [SEL_W-1:0] b0 = pb_lo_sel[B0_LSB +: SEL_W];

    // timer outputs driven onto a0 and a7
    assign sel.a_timer_drv = {a7 == SEL_C2, 6'h00, a0 == SEL_C3};

    // analog and reference pins lose the digital driver
    assign sel.a_analog = {a7 == SEL_C3, a6 == SEL_C3,
                           a5 == SEL_C2 || a5 == SEL_C3,
                           a4 == SEL_C3, 4'h0};
    // b3 and b1 have no decode: reserved codes stay gpio
    assign sel.b_analog = {3'h0, b0 == SEL_C3};

    // converter channel and reference enables, channel six on top
    assign sel.analog_en = {a7 == SEL_C3, a6 == SEL_C3, a5 == SEL_C3,
                            a4 == SEL_C3, 2'h0, b0 == SEL_C3};
    assign sel.vref_en = (a5 == SEL_C2);

    // shared digital inputs
    assign sel.std_cap_en = (a0 != SEL_C3);
    assign sel.per_cap_en = (a7 != SEL_C2) && (a7 != SEL_C3);
    assign sel.per_clk_en = (a4 != SEL_C3);
    assign sel.std_clk_en = (b2 != SEL_C3);
    assign sel.ext_int_en = (b0 != SEL_C3);
endmodule : pfs_decode

// *** pfs_top.sv ***
/*
 * pfs_top: pin function selector with port data, direction and
 * wake-up logic behind an AXI4-Lite slave.
 * Assumes pins are asynchronous; timers and sleep_mode share aclk.
 */
// What this block does
// - A0 field: codes 00-10 gpio with standard capture, 11 standard timer out.
// - A7 field: 00/01 gpio with periodic capture, 10 periodic out, 11 ch6.
// - A6 field: codes 00-10 gpio, 11 analog channel five.
// - A5 field: 00/01 gpio, 10 voltage reference, 11 analog channel four.
// - A4 field: 00-10 gpio with periodic clock input, 11 channel three.
// - B3 field: 00 gpio, other codes reserved.
// - B2 field: 00-10 gpio with standard timer clock input.
// - B1 field: 00 gpio, other codes reserved.
// - B0 field: 00-10 gpio with external interrupt, 11 channel zero.
// - A0 select register holds two bits; upper bits read zero.
// - Reset sets all port data and direction registers to ones.
// - Output pin drives high unless data written first.
// - Bit set and clear read the whole port, modify, write back.
// - Falling edge on wake-enabled port A pin wakes from sleep.
// - Direction one is input, zero output; output reads the latch.
// - Wake-up only for gpio input pins while in sleep.
`timescale 1ns/100ps
module pfs_top
    import pfs_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output wire logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output wire logic              wready,
    output wire logic [1:0]        bresp,
    output wire logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output wire logic              arready,
    output wire logic [31:0]       rdata,
    output wire logic [1:0]        rresp,
    output wire logic              rvalid,
    input  wire logic              rready,
    input  wire logic [PA_W-1:0]   pa_in,
    output wire logic [PA_W-1:0]   pa_out,
    output wire logic [PA_W-1:0]   pa_oe,
    input  wire logic [PB_W-1:0]   pb_in,
    output wire logic [PB_W-1:0]   pb_out,
    output wire logic [PB_W-1:0]   pb_oe,
    input  wire logic              standard_timer_out,
    input  wire logic              periodic_timer_out,
    output wire logic              standard_timer_capture_in,
    output wire logic              standard_timer_clock_in,
    output wire logic              periodic_timer_capture_in,
    output wire logic              periodic_timer_clock_in,
    output wire logic              external_interrupt_in,
    output wire logic [AN_W-1:0]   analog_channel_en,
    output wire logic              vref_en,
    input  wire logic              sleep_mode,
    output wire logic              wake_req
);
    ////////////////////////////////////////////////////////////////////
    // state
    logic [SEL_W-1:0]  pa_lo_sel_q;
    logic [7:0]        pa_hi_sel_q;
    logic [7:0]        pb_lo_sel_q;
    logic [PA_W-1:0]   pa_data_q;
    logic [PA_W-1:0]   pa_dir_q;
    logic [PB_W-1:0]   pb_data_q;
    logic [PB_W-1:0]   pb_dir_q;
    logic [PA_W-1:0]   wake_en_q;
    logic [PA_W-1:0]   pa_s1_q;
    logic [PA_W-1:0]   pa_s2_q;
    logic [PA_W-1:0]   pa_s3_q;
    logic [PB_W-1:0]   pb_s1_q;
    logic [PB_W-1:0]   pb_s2_q;
    logic              aw_rdy_q;
    logic              w_rdy_q;
    logic              ar_rdy_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0]        wdata_q;
    logic              wstrb0_q;
    logic [PA_W-1:0]   pa_out_q;
    logic [PA_W-1:0]   pa_oe_q;
    logic [PB_W-1:0]   pb_out_q;
    logic [PB_W-1:0]   pb_oe_q;
    logic              std_cap_q;
    logic              std_clk_q;
    logic              per_cap_q;
    logic              per_clk_q;
    logic              ext_int_q;
    logic [AN_W-1:0]   analog_en_q;
    logic              vref_en_q;
    logic              wake_q;

    pfs_sel_if sel ();

    pfs_decode pfs_decode_inst (
        .pa_lo_sel (pa_lo_sel_q),
        .pa_hi_sel (pa_hi_sel_q),
        .pb_lo_sel (pb_lo_sel_q),
        .sel       (sel)
    );

    ////////////////////////////////////////////////////////////////////
    // bus handshake decode
    wire logic aw_take = awvalid && aw_rdy_q;
    wire logic w_take  = wvalid && w_rdy_q;
    wire logic ar_take = arvalid && ar_rdy_q;
    wire logic do_wr   = !aw_rdy_q && !w_rdy_q && !bvalid_q;
    wire logic b_done  = bvalid_q && bready;
    wire logic r_done  = rvalid_q && rready;
    wire logic wr_en   = do_wr && wstrb0_q;

    // write address decode
    wire logic [ADDR_W-1:0] wa = {awaddr_q[ADDR_W-1:2], 2'h0};
    wire logic wr_pa_lo  = wr_en && (wa == OFF_PA_LO_SEL);
    wire logic wr_pa_hi  = wr_en && (wa == OFF_PA_HI_SEL);
    wire logic wr_pb_lo  = wr_en && (wa == OFF_PB_LO_SEL);
    wire logic wr_pa_dat = wr_en && (wa == OFF_PA_DATA);
    wire logic wr_pa_dir = wr_en && (wa == OFF_PA_DIR);
    wire logic wr_pb_dat = wr_en && (wa == OFF_PB_DATA);
    wire logic wr_pb_dir = wr_en && (wa == OFF_PB_DIR);
    wire logic wr_wake   = wr_en && (wa == OFF_WAKE_EN);
    wire logic wr_bop    = wr_en && (wa == OFF_BIT_OP);
    wire logic wa_hit    = wr_pa_lo || wr_pa_hi || wr_pb_lo || wr_pa_dat
                        || wr_pa_dir || wr_pb_dat || wr_pb_dir || wr_wake
                        || wr_bop || !wstrb0_q;

    ////////////////////////////////////////////////////////////////////
    // port read view: input pins show the pin, outputs the latch
    wire logic [PA_W-1:0] pa_view =
        (pa_dir_q & pa_s2_q) | (~pa_dir_q & pa_data_q);
    wire logic [PB_W-1:0] pb_view =
        (pb_dir_q & pb_s2_q) | (~pb_dir_q & pb_data_q);

    // bit set and clear: whole port read, one bit changed, written back
    wire logic [2:0] bop_idx = wdata_q[BOP_IDX_LSB +: 3];
    wire logic bop_val = wdata_q[BOP_VAL];
    wire logic bop_dir = wdata_q[BOP_DIR];
    wire logic bop_pb  = wdata_q[BOP_PB];
    wire logic [7:0] bop_cur =
        bop_dir ? (bop_pb ? {4'h0, pb_dir_q} : pa_dir_q)
                : (bop_pb ? {4'h0, pb_view} : pa_view);
    wire logic [7:0] bop_mask = 8'h01 << bop_idx;
    wire logic [7:0] rmw_byte =
        bop_val ? (bop_cur | bop_mask) : (bop_cur & ~bop_mask);
    wire logic bop_pa_dat = wr_bop && !bop_dir && !bop_pb;
    wire logic bop_pa_dir = wr_bop && bop_dir && !bop_pb;
    wire logic bop_pb_dat = wr_bop && !bop_dir && bop_pb;
    wire logic bop_pb_dir = wr_bop && bop_dir && bop_pb;

    // next port register values
    wire logic [PA_W-1:0] pa_data_d = wr_pa_dat ? wdata_q :
        (bop_pa_dat ? rmw_byte : pa_data_q);
    wire logic [PA_W-1:0] pa_dir_d = wr_pa_dir ? wdata_q :
        (bop_pa_dir ? rmw_byte : pa_dir_q);
    wire logic [PB_W-1:0] pb_data_d = wr_pb_dat ? wdata_q[PB_W-1:0] :
        (bop_pb_dat ? rmw_byte[PB_W-1:0] : pb_data_q);
    wire logic [PB_W-1:0] pb_dir_d = wr_pb_dir ? wdata_q[PB_W-1:0] :
        (bop_pb_dir ? rmw_byte[PB_W-1:0] : pb_dir_q);

    ////////////////////////////////////////////////////////////////////
    // read mux, upper bits read zero
    wire logic [ADDR_W-1:0] ra = {araddr[ADDR_W-1:2], 2'h0};
    wire logic ra_hit = (ra == OFF_PA_LO_SEL) || (ra == OFF_PA_HI_SEL)
        || (ra == OFF_PB_LO_SEL) || (ra == OFF_PA_DATA)
        || (ra == OFF_PA_DIR) || (ra == OFF_PB_DATA)
        || (ra == OFF_PB_DIR) || (ra == OFF_WAKE_EN)
        || (ra == OFF_BIT_OP);
    wire logic [7:0] rd_byte =
        (ra == OFF_PA_LO_SEL) ? {6'h00, pa_lo_sel_q} :
        (ra == OFF_PA_HI_SEL) ? pa_hi_sel_q :
        (ra == OFF_PB_LO_SEL) ? pb_lo_sel_q :
        (ra == OFF_PA_DATA)   ? pa_view :
        (ra == OFF_PA_DIR)    ? pa_dir_q :
        (ra == OFF_PB_DATA)   ? {4'h0, pb_view} :
        (ra == OFF_PB_DIR)    ? {4'h0, pb_dir_q} :
        (ra == OFF_WAKE_EN)   ? wake_en_q : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // pin routing
    wire logic [PA_W-1:0] a_timer_val =
        {periodic_timer_out, 6'h00, standard_timer_out};
    wire logic [PA_W-1:0] pa_out_d = (sel.a_timer_drv & a_timer_val)
        | (~sel.a_timer_drv & pa_data_q);
    wire logic [PA_W-1:0] pa_oe_d = (sel.a_timer_drv | ~pa_dir_q)
        & ~sel.a_analog;
    wire logic [PB_W-1:0] pb_oe_d = ~pb_dir_q & ~sel.b_analog;
    wire logic [PA_W-1:0] a_gpio_in =
        pa_dir_q & ~sel.a_timer_drv & ~sel.a_analog;
    wire logic [PA_W-1:0] pa_fall = pa_s3_q & ~pa_s2_q;
    wire logic wake_d = sleep_mode
        && |(pa_fall & wake_en_q & a_gpio_in);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge aclk)
    begin
        pa_s1_q <= pa_in;
        pa_s2_q <= pa_s1_q;
        pa_s3_q <= pa_s2_q;
        pb_s1_q <= pb_in;
        pb_s2_q <= pb_s1_q;
    end

    // write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_rdy_q <= 1'b1;
            w_rdy_q  <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_rdy_q <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (w_take)
            begin
                w_rdy_q  <= 1'b0;
                wdata_q  <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
            if (do_wr)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done)
            begin
                bvalid_q <= 1'b0;
                aw_rdy_q <= 1'b1;
                w_rdy_q  <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end
        else if (ar_take)
        begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q  <= ra_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= {24'h000000, rd_byte};
        end
        else if (r_done)
        begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // software registers, ports reset to all ones
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pa_lo_sel_q <= RST_SEL[SEL_W-1:0];
            pa_hi_sel_q <= RST_SEL;
            pb_lo_sel_q <= RST_SEL;
            pa_data_q   <= RST_PORT;
            pa_dir_q    <= RST_PORT;
            pb_data_q   <= RST_PORT[PB_W-1:0];
            pb_dir_q    <= RST_PORT[PB_W-1:0];
            wake_en_q   <= RST_WAKE;
        end
        else
        begin
            if (wr_pa_lo)
                pa_lo_sel_q <= wdata_q[SEL_W-1:0];
            if (wr_pa_hi)
                pa_hi_sel_q <= wdata_q;
            if (wr_pb_lo)
                pb_lo_sel_q <= wdata_q;
            if (wr_wake)
                wake_en_q <= wdata_q;
            pa_data_q <= pa_data_d;
            pa_dir_q  <= pa_dir_d;
            pb_data_q <= pb_data_d;
            pb_dir_q  <= pb_dir_d;
        end
    end

    // registered pin, peripheral and wake outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pa_out_q    <= '0;
            pa_oe_q     <= '0;
            pb_out_q    <= '0;
            pb_oe_q     <= '0;
            std_cap_q   <= 1'b0;
            std_clk_q   <= 1'b0;
            per_cap_q   <= 1'b0;
            per_clk_q   <= 1'b0;
            ext_int_q   <= 1'b0;
            analog_en_q <= '0;
            vref_en_q   <= 1'b0;
            wake_q      <= 1'b0;
        end
        else
        begin
            pa_out_q    <= pa_out_d;
            pa_oe_q     <= pa_oe_d;
            pb_out_q    <= pb_data_q;
            pb_oe_q     <= pb_oe_d;
            std_cap_q   <= sel.std_cap_en && pa_s2_q[0];
            per_cap_q   <= sel.per_cap_en && pa_s2_q[7];
            per_clk_q   <= sel.per_clk_en && pa_s2_q[4];
            std_clk_q   <= sel.std_clk_en && pb_s2_q[2];
            ext_int_q   <= sel.ext_int_en && pb_s2_q[0];
            analog_en_q <= sel.analog_en;
            vref_en_q   <= sel.vref_en;
            wake_q      <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output ports
    assign awready = aw_rdy_q;
    assign wready  = w_rdy_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = ar_rdy_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign pa_out  = pa_out_q;
    assign pa_oe   = pa_oe_q;
    assign pb_out  = pb_out_q;
    assign pb_oe   = pb_oe_q;
    assign standard_timer_capture_in = std_cap_q;
    assign standard_timer_clock_in   = std_clk_q;
    assign periodic_timer_capture_in = per_cap_q;
    assign periodic_timer_clock_in   = per_clk_q;
    assign external_interrupt_in     = ext_int_q;
    assign analog_channel_en = analog_en_q;
    assign vref_en  = vref_en_q;
    assign wake_req = wake_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a0_timer_a: assert property (
        pa_lo_sel_q == SEL_C3 |=> pa_oe[0]
        && pa_out[0] == $past(standard_timer_out))
        else $error("a0 not driving standard timer output");
    a7_timer_a: assert property (
        pa_hi_sel_q[A7_LSB +: SEL_W] == SEL_C2 |=> pa_oe[7]
        && !periodic_timer_capture_in)
        else $error("a7 periodic output routing wrong");
    a6_analog_a: assert property (
        pa_hi_sel_q[A6_LSB +: SEL_W] == SEL_C3 |=> !pa_oe[6]
        && analog_channel_en[5])
        else $error("a6 analog routing wrong");
    a5_vref_a: assert property (
        pa_hi_sel_q[A5_LSB +: SEL_W] == SEL_C2 |=> vref_en && !pa_oe[5]
        && !analog_channel_en[4])
        else $error("a5 reference routing wrong");
    a4_clock_a: assert property (
        pa_hi_sel_q[A4_LSB +: SEL_W] != SEL_C3 |=>
        periodic_timer_clock_in == $past(pa_s2_q[4]))
        else $error("a4 periodic clock not passed");
    b_reserved_a: assert property (
        ##1 pb_oe[3] == !$past(pb_dir_q[3], 1)
        && pb_oe[1] == !$past(pb_dir_q[1], 1))
        else $error("reserved code changed b3 or b1");
    b2_clock_a: assert property (
        pb_lo_sel_q[B2_LSB +: SEL_W] != SEL_C3 |=>
        standard_timer_clock_in == $past(pb_s2_q[2]))
        else $error("b2 standard clock not passed");
    b0_int_a: assert property (
        pb_lo_sel_q[B0_LSB +: SEL_W] == SEL_C3 |=> !pb_oe[0]
        && !external_interrupt_in && analog_channel_en[0])
        else $error("b0 analog routing wrong");
    sel0_read_a: assert property (
        ar_take && ra == OFF_PA_LO_SEL |=> rvalid && rdata[31:2] == '0)
        else $error("upper bits of a0 select not zero");
    port_reset_a: assert property (
        $past(!aresetn) |-> pa_data_q == RST_PORT && pa_dir_q == RST_PORT
        && pa_oe_q == '0)
        else $error("ports not all inputs after reset");
    bit_op_a: assert property (
        bop_pa_dat && !wr_pa_dat |=> pa_data_q == $past(rmw_byte))
        else $error("bit operation did not write back byte");
    wake_gate_a: assert property (
        !sleep_mode |=> !wake_req)
        else $error("wake raised while awake");
    wake_fire_a: assert property (
        sleep_mode && (pa_fall[0] && wake_en_q[0] && a_gpio_in[0])
        |=> wake_req)
        else $error("wake missed on falling edge");
endmodule : pfs_top

// *** pfs_top_tb.sv ***
/*
 * pfs_top_tb: register and pin tests of the pin function selector.
 * Assumes pfs_pkg offsets and the AXI4-Lite slave of pfs_top.
 */
`timescale 1ns/100ps
module pfs_top_tb
    import pfs_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sleep_mode = 1'b0;
    logic standard_timer_out = 1'b0, periodic_timer_out = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wake_req, vref_en;
    logic standard_timer_capture_in, standard_timer_clock_in;
    logic periodic_timer_capture_in, periodic_timer_clock_in;
    logic external_interrupt_in;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [3:0]        wstrb = 4'hf;
    logic [1:0]        bresp, rresp;
    logic [PA_W-1:0]   pa_in = 8'hff, pa_out, pa_oe;
    logic [PB_W-1:0]   pb_in = 4'hf, pb_out, pb_oe;
    logic [AN_W-1:0]   analog_channel_en;
    int                mismatches = 0, cmp_count = 0, wakes = 0, n;

    ////////////////////////////////////////////////////////////////////////
    // device under test and clock
    pfs_top pfs_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pa_in, .pa_out,
        .pa_oe, .pb_in, .pb_out, .pb_oe, .standard_timer_out,
        .periodic_timer_out, .standard_timer_capture_in,
        .standard_timer_clock_in, .periodic_timer_capture_in,
        .periodic_timer_clock_in, .external_interrupt_in, .analog_channel_en,
        .vref_en, .sleep_mode, .wake_req);
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end
    // counts wake pulses
    always @(posedge aclk) if (wake_req === 1'b1) wakes++;

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge aclk);
    endtask : cyc
    task automatic tmo();
        if (n >= 50)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask : tmo
    // write with address and data offered together
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        tmo();
        bready <= 1'b0;
        chk(34'(bresp), 34'(er));
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        tmo();
        rready <= 1'b0;
        chk({rresp, rdata}, {er, 24'h0, e});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        cyc(10);
        aresetn <= 1'b1;
        rd(OFF_PA_LO_SEL, RST_SEL); rd(OFF_PA_DATA, RST_PORT);
        rd(OFF_PB_DIR, 8'h0f); rd(OFF_WAKE_EN, RST_WAKE);
        wr(OFF_PA_LO_SEL, 8'hff); rd(OFF_PA_LO_SEL, 8'h03);
        wr(6'h3c, 8'h55, RESP_SLVERR); rd(6'h3c, 8'h00, RESP_SLVERR);
        $display("test registers done");
        wr(OFF_PA_LO_SEL, 8'h00); wr(OFF_PA_DIR, 8'hfe); cyc(2);
        chk(34'({pa_oe, pa_out[0]}), 34'({8'h01, 1'b1}));
        wr(OFF_PA_LO_SEL, 8'h03); cyc(2);
        chk(34'({pa_oe[0], pa_out[0]}), 34'(2'b10));
        standard_timer_out <= 1'b1; cyc(2);
        chk(34'(pa_out[0]), 34'(1'b1));
        pa_in <= 8'h0f; wr(OFF_BIT_OP, 8'h00); cyc(4);
        rd(OFF_PA_DATA, 8'h0e); wr(OFF_PA_DIR, 8'h00);
        rd(OFF_PA_DATA, 8'h0e); $display("test port done");
        wr(OFF_PA_HI_SEL, 8'hfb); wr(OFF_PB_LO_SEL, 8'h03); cyc(2);
        chk(34'({analog_channel_en, vref_en, pa_oe[7:4]}),
            34'({7'h69, 1'b1, 4'h0}));
        wr(OFF_PA_HI_SEL, 8'h00); wr(OFF_PB_LO_SEL, 8'h00);
        wr(OFF_PA_LO_SEL, 8'h00); wr(OFF_PA_DIR, 8'hff);
        pa_in <= 8'hff; cyc(4);
        chk(34'({standard_timer_capture_in, periodic_timer_capture_in,
            periodic_timer_clock_in, standard_timer_clock_in,
            external_interrupt_in}), 34'(5'h1f));
        wr(OFF_PA_HI_SEL, 8'h80); periodic_timer_out <= 1'b1; cyc(2);
        chk(34'({pa_oe[7], pa_out[7], periodic_timer_capture_in}),
            34'(3'b110));
        periodic_timer_out <= 1'b0; wr(OFF_PA_HI_SEL, 8'h00);
        wr(OFF_PB_LO_SEL, 8'hff); cyc(2);
        chk(34'({standard_timer_clock_in, external_interrupt_in,
            analog_channel_en}), 34'({2'b00, 7'h01}));
        wr(OFF_PB_DIR, 8'h00); cyc(2);
        chk(34'({pb_oe, pb_out}), 34'({4'he, 4'hf}));
        $display("test functions done");
        wr(OFF_WAKE_EN, 8'h01); sleep_mode <= 1'b1; cyc(4); wakes = 0;
        pa_in <= 8'hfe; cyc(6); pa_in <= 8'hfc; cyc(6);
        chk(34'(wakes), 34'(1));
        sleep_mode <= 1'b0; pa_in <= 8'hff; cyc(6); pa_in <= 8'hfe; cyc(6);
        chk(34'(wakes), 34'(1)); $display("test wake done");
        report_and_stop();
    end
endmodule : pfs_top_tb
